//--- design/sensor_prog_register_bank.sv
// Register bank of the programmable switch sensor, behind decoded telegrams
//
// Summary of operation
// - Output low level, address 1, 8 bits, read, write and store.
// - Output high level, address 2, 9 bits, read, write and store.
// - Quiescent level, address 3, 11-bit two's complement, read, write, store.
// - Gain setting, address 4, 14-bit sign-magnitude, read, write, store.
// - Temperature coefficient, address 11: square term, linear term, group.
// - Configuration, address 5: range, offset sign, output mode, filter, offset.
// - Processed value readout, address 9, read only, returned LSB first.
// - Converter readout, address 7, read only; writes do nothing.
// - Disable register, address 15, write only; only 80F deactivates.
// - Activate pulse on output pin or power cycle reactivates sensor.
// - Writes take low bits of data field; reads align value at bit 13.
// - Store is erase then program, both with address zero, on all.
// - Erase and program update every nonvolatile word in parallel.
// - Lock register at address 6, 2 bits, effective after next power-up.
// - Command 4 programs nonvolatile words from volatile copies, not lock.
// - Command 5 erases nonvolatile words, not lock; 2 reads, 3 writes.
module sensor_prog_register_bank
	import sensor_prog_pkg::*;
#(
	parameter int GP_WORDS = GP_WORDS_DEF
) (
	input  wire logic                   clk_in,
	input  wire logic                   arst_n_in,
	input  wire logic                   cmd_valid_in,
	input  wire logic [2:0]             cmd_code_in,
	input  wire logic [3:0]             cmd_addr_in,
	input  wire logic [DATA_W-1:0]      payload_field_in,
	input  wire logic [READOUT_W-1:0]   converter_sample_view_in,
	input  wire logic [READOUT_W-1:0]   processed_value_capture_in,
	input  wire logic                   activate_pin_in,
	output logic                        ack_out,
	output logic                        rsp_valid_out,
	output logic      [DATA_W-1:0]      rsp_data_out,
	output logic                        sensor_active_out,
	output logic                        lock_active_out,
	output logic                        load_busy_out,
	output logic      [LOW_LEVEL_W-1:0] output_low_level_out,
	output logic     [HIGH_LEVEL_W-1:0] output_high_level_out,
	output logic      [QUIESCENT_W-1:0] quiescent_output_level_out,
	output logic           [GAIN_W-1:0] gain_setting_out,
	output logic                  [2:0] range_select_out,
	output logic                        offset_fix_sign_out,
	output logic        [CFG_OUT_W-1:0] output_behaviour_select_out,
	output logic     [CFG_FILTER_W-1:0] filter_select_out,
	output logic                        offset_fix_out,
	output logic          [TC_SQ_W-1:0] square_term_value_out,
	output logic         [TC_LIN_W-1:0] linear_term_value_out,
	output logic         [TC_GRP_W-1:0] coefficient_group_out
);

	localparam int WORDS = FIXED_WORDS + GP_WORDS;
	localparam int IDX_W = $clog2(WORDS);

	typedef enum logic [1:0] {ST_LOAD, ST_CAPTURE, ST_ARM, ST_IDLE} state_t;

	initial begin
		if (GP_WORDS < 1 || GP_WORDS > 3) begin
			$error("sensor_prog_register_bank: GP_WORDS must be 1 to 3");
		end
	end

	state_t                   state_reg, state_next;
	logic [DATA_W-1:0]        ram_reg [WORDS];
	logic [DATA_W-1:0]        ram_next [WORDS];
	logic [WORDS*DATA_W-1:0]  ram_flat;
	logic [IDX_W-1:0]         idx_reg, idx_next;
	logic [GP_PTR_W-1:0]      gp_ptr_reg, gp_ptr_next;
	logic                     active_reg, active_next;
	logic                     lock_reg, lock_next;
	logic                     ack_reg, ack_next;
	logic                     rsp_valid_reg, rsp_valid_next;
	logic [DATA_W-1:0]        rsp_data_reg, rsp_data_next;
	logic                     act_meta_reg, act_sync_reg, act_prev_reg;
	logic                     act_edge;
	logic                     erase_pulse, program_pulse, lock_we;
	logic [DATA_W-1:0]        bank_rd_data;
	logic [PROTECT_W-1:0]     bank_lock;
	logic [IDX_W-1:0]         bank_rd_index;
	logic                     busy_reg, busy_next;

	function automatic int word_width(input int idx);
		case (idx)
			IDX_LOW_LEVEL:  return LOW_LEVEL_W;
			IDX_HIGH_LEVEL: return HIGH_LEVEL_W;
			IDX_QUIESCENT:  return QUIESCENT_W;
			IDX_GAIN:       return GAIN_W;
			IDX_CONFIG:     return CONFIG_W;
			IDX_TEMP_COEF:  return TEMP_COEF_W;
			default:        return SPARE_W;
		endcase
	endfunction

	function automatic logic [DATA_W-1:0] low_mask(input int w);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int b = 0; b < DATA_W; b++) begin
			m[b] = (b < w);
		end
		return m;
	endfunction

	// Left-aligns a value of width w so that its MSB sits at bit 13
	function automatic logic [DATA_W-1:0] align_read(
		input logic [DATA_W-1:0] v,
		input int                w
	);
		return v << (DATA_W - w);
	endfunction

	function automatic logic [DATA_W-1:0] reverse_bits(
		input logic [DATA_W-1:0] v
	);
		logic [DATA_W-1:0] r;
		r = '0;
		for (int b = 0; b < DATA_W; b++) begin
			r[b] = v[DATA_W-1-b];
		end
		return r;
	endfunction

	// Bank index of an addressed volatile word, or -1 if none
	function automatic int word_index(
		input logic [3:0]          addr,
		input logic [GP_PTR_W-1:0] ptr
	);
		case (addr)
			ADDR_LOW_LEVEL:  return IDX_LOW_LEVEL;
			ADDR_HIGH_LEVEL: return IDX_HIGH_LEVEL;
			ADDR_QUIESCENT:  return IDX_QUIESCENT;
			ADDR_GAIN:       return IDX_GAIN;
			ADDR_CONFIG:     return IDX_CONFIG;
			ADDR_TEMP_COEF:  return IDX_TEMP_COEF;
			ADDR_SPARE_0:    return IDX_SPARE_0;
			ADDR_SPARE_123:  return IDX_SPARE_1 + int'(ptr);
			default:         return -1;
		endcase
	endfunction

	for (genvar i = 0; i < WORDS; i++) begin : g_flat
		assign ram_flat[i*DATA_W +: DATA_W] = ram_reg[i];
	end

	assign act_edge = act_sync_reg & ~act_prev_reg;
	assign bank_rd_index = idx_reg;

	nv_word_bank #(
		.WORDS (WORDS),
		.WIDTH (DATA_W),
		.LOCKW (PROTECT_W)
	) u_bank (
		.clk_in       (clk_in),
		.arst_n_in    (arst_n_in),
		.erase_in     (erase_pulse),
		.program_in   (program_pulse),
		.prog_data_in (ram_flat),
		.rd_index_in  (bank_rd_index),
		.rd_data_out  (bank_rd_data),
		.lock_we_in   (lock_we),
		.lock_data_in (payload_field_in[PROTECT_W-1:0]),
		.lock_out     (bank_lock)
	);

	always_comb begin
		int  wi;
		int  ww;
		logic take;
		wi             = -1;
		ww             = 0;
		take           = 1'b0;
		state_next     = state_reg;
		idx_next       = idx_reg;
		gp_ptr_next    = gp_ptr_reg;
		active_next    = active_reg;
		lock_next      = lock_reg;
		ack_next       = 1'b0;
		rsp_valid_next = 1'b0;
		rsp_data_next  = rsp_data_reg;
		erase_pulse    = 1'b0;
		program_pulse  = 1'b0;
		lock_we        = 1'b0;
		for (int i = 0; i < WORDS; i++) begin
			ram_next[i] = ram_reg[i];
		end
		if (act_edge) begin
			active_next = 1'b1;
		end
		case (state_reg)
			// Power-up copies every stored word into its volatile copy
			ST_LOAD: begin
				state_next = ST_CAPTURE;
			end
			ST_CAPTURE: begin
				ram_next[idx_reg] = bank_rd_data;
				if (int'(idx_reg) == WORDS - 1) begin
					state_next = ST_ARM;
				end else begin
					idx_next   = idx_reg + 1'b1;
					state_next = ST_LOAD;
				end
			end
			ST_ARM: begin
				// Lock is sampled once per power-up, never live
				lock_next  = |bank_lock;
				state_next = ST_IDLE;
			end
			ST_IDLE: begin
				wi = word_index(cmd_addr_in, gp_ptr_reg);
				if (wi >= 0) begin
					ww = word_width(wi);
				end
				take = cmd_valid_in && active_reg && !act_edge;
				if (take) begin
					case (cmd_code_in)
						CMD_READ: begin
							ack_next       = 1'b1;
							rsp_valid_next = 1'b1;
							rsp_data_next  = '0;
							if (wi >= 0) begin
								rsp_data_next = align_read(ram_reg[wi], ww);
							end else if (cmd_addr_in == ADDR_PROTECT) begin
								rsp_data_next = align_read(
									{{(DATA_W-PROTECT_W){1'b0}}, bank_lock},
									PROTECT_W);
							end else if (cmd_addr_in == ADDR_CONVERTER) begin
								rsp_data_next = converter_sample_view_in;
							end else if (cmd_addr_in == ADDR_PROCESSED) begin
								rsp_data_next = reverse_bits(
									processed_value_capture_in);
							end
						end
						CMD_WRITE: begin
							if (!lock_reg) begin
								ack_next = 1'b1;
								if (wi >= 0) begin
									ram_next[wi] = payload_field_in
										& low_mask(ww);
								end else if (cmd_addr_in == ADDR_PROTECT) begin
									lock_we = 1'b1;
								end else if (cmd_addr_in == ADDR_DISABLE &&
									payload_field_in[DISABLE_W-1:0] ==
									DISABLE_CODE) begin
									active_next = 1'b0;
								end
							end
						end
						CMD_PROGRAM: begin
							if (!lock_reg && cmd_addr_in == ADDR_STORE) begin
								ack_next      = 1'b1;
								program_pulse = 1'b1;
							end
						end
						CMD_ERASE: begin
							if (!lock_reg && cmd_addr_in == ADDR_STORE) begin
								ack_next    = 1'b1;
								erase_pulse = 1'b1;
							end
						end
						default: begin
							ack_next = 1'b0;
						end
					endcase
					// Spare words walk in order; word 0 restarts the walk
					if ((cmd_code_in == CMD_READ ||
						(cmd_code_in == CMD_WRITE && !lock_reg))) begin
						if (cmd_addr_in == ADDR_SPARE_0) begin
							gp_ptr_next = '0;
						end else if (cmd_addr_in == ADDR_SPARE_123) begin
							if (int'(gp_ptr_reg) == GP_WORDS - 1) begin
								gp_ptr_next = '0;
							end else begin
								gp_ptr_next = gp_ptr_reg + 1'b1;
							end
						end
					end
				end
			end
			default: begin
				state_next = ST_LOAD;
			end
		endcase
		busy_next = (state_next != ST_IDLE);
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg     <= ST_LOAD;
			idx_reg       <= '0;
			gp_ptr_reg    <= '0;
			active_reg    <= 1'b1;
			busy_reg      <= 1'b1;
			lock_reg      <= 1'b0;
			ack_reg       <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg  <= '0;
			act_meta_reg  <= 1'b0;
			act_sync_reg  <= 1'b0;
			act_prev_reg  <= 1'b0;
			for (int i = 0; i < WORDS; i++) begin
				ram_reg[i] <= '0;
			end
		end else begin
			state_reg     <= state_next;
			idx_reg       <= idx_next;
			gp_ptr_reg    <= gp_ptr_next;
			active_reg    <= active_next;
			busy_reg      <= busy_next;
			lock_reg      <= lock_next;
			ack_reg       <= ack_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_data_reg  <= rsp_data_next;
			act_meta_reg  <= activate_pin_in;
			act_sync_reg  <= act_meta_reg;
			act_prev_reg  <= act_sync_reg;
			for (int i = 0; i < WORDS; i++) begin
				ram_reg[i] <= ram_next[i];
			end
		end
	end

	// Outputs all come straight from flip-flops; setting outputs are slices of the volatile copies
	always_comb begin
		ack_out                    = ack_reg;
		rsp_valid_out              = rsp_valid_reg;
		rsp_data_out               = rsp_data_reg;
		sensor_active_out          = active_reg;
		lock_active_out            = lock_reg;
		load_busy_out              = busy_reg;
		output_low_level_out       = ram_reg[IDX_LOW_LEVEL][LOW_LEVEL_W-1:0];
		output_high_level_out      = ram_reg[IDX_HIGH_LEVEL][HIGH_LEVEL_W-1:0];
		quiescent_output_level_out = ram_reg[IDX_QUIESCENT][QUIESCENT_W-1:0];
		gain_setting_out           = ram_reg[IDX_GAIN][GAIN_W-1:0];
		range_select_out           = {ram_reg[IDX_CONFIG][CFG_RANGE_HI_BIT],
			ram_reg[IDX_CONFIG][CFG_RANGE_LO_LSB +: CFG_RANGE_LO_W]};
		offset_fix_sign_out        = ram_reg[IDX_CONFIG][CFG_OC_SIGN_BIT];
		output_behaviour_select_out =
			ram_reg[IDX_CONFIG][CFG_OUT_LSB +: CFG_OUT_W];
		filter_select_out          =
			ram_reg[IDX_CONFIG][CFG_FILTER_LSB +: CFG_FILTER_W];
		offset_fix_out             = ram_reg[IDX_CONFIG][CFG_OC_BIT];
		square_term_value_out      =
			ram_reg[IDX_TEMP_COEF][TC_SQ_LSB +: TC_SQ_W];
		linear_term_value_out      =
			ram_reg[IDX_TEMP_COEF][TC_LIN_LSB +: TC_LIN_W];
		coefficient_group_out      =
			ram_reg[IDX_TEMP_COEF][TC_GRP_LSB +: TC_GRP_W];
	end

endmodule

//--- design/sensor_prog_pkg.sv
// Constants shared by the sensor programming register bank
package sensor_prog_pkg;

	localparam int DATA_W       = 14;
	localparam int GP_PTR_W     = 2;
	localparam int GP_WORDS_DEF = 3;
	localparam int FIXED_WORDS  = 7;

	localparam logic [3:0] ADDR_LOW_LEVEL  = 4'h1;
	localparam logic [3:0] ADDR_HIGH_LEVEL = 4'h2;
	localparam logic [3:0] ADDR_QUIESCENT  = 4'h3;
	localparam logic [3:0] ADDR_GAIN       = 4'h4;
	localparam logic [3:0] ADDR_CONFIG     = 4'h5;
	localparam logic [3:0] ADDR_PROTECT    = 4'h6;
	localparam logic [3:0] ADDR_CONVERTER  = 4'h7;
	localparam logic [3:0] ADDR_SPARE_123  = 4'h8;
	localparam logic [3:0] ADDR_PROCESSED  = 4'h9;
	localparam logic [3:0] ADDR_TEMP_COEF  = 4'hB;
	localparam logic [3:0] ADDR_SPARE_0    = 4'hC;
	localparam logic [3:0] ADDR_DISABLE    = 4'hF;
	localparam logic [3:0] ADDR_STORE      = 4'h0;

	localparam logic [2:0] CMD_READ    = 3'h2;
	localparam logic [2:0] CMD_WRITE   = 3'h3;
	localparam logic [2:0] CMD_PROGRAM = 3'h4;
	localparam logic [2:0] CMD_ERASE   = 3'h5;

	localparam logic [11:0] DISABLE_CODE = 12'h80F;
	localparam int          DISABLE_W    = 12;

	// Index of each volatile word in the bank; spare words 1..3 follow
	localparam int IDX_LOW_LEVEL  = 0;
	localparam int IDX_HIGH_LEVEL = 1;
	localparam int IDX_QUIESCENT  = 2;
	localparam int IDX_GAIN       = 3;
	localparam int IDX_CONFIG     = 4;
	localparam int IDX_TEMP_COEF  = 5;
	localparam int IDX_SPARE_0    = 6;
	localparam int IDX_SPARE_1    = 7;

	localparam int LOW_LEVEL_W  = 8;
	localparam int HIGH_LEVEL_W = 9;
	localparam int QUIESCENT_W  = 11;
	localparam int GAIN_W       = 14;
	localparam int CONFIG_W     = 10;
	localparam int TEMP_COEF_W  = 10;
	localparam int SPARE_W      = 13;
	localparam int PROTECT_W    = 2;
	localparam int READOUT_W    = 14;

	localparam int TC_SQ_LSB    = 0;
	localparam int TC_SQ_W      = 3;
	localparam int TC_LIN_LSB   = 3;
	localparam int TC_LIN_W     = 5;
	localparam int TC_GRP_LSB   = 8;
	localparam int TC_GRP_W     = 2;

	localparam int CFG_RANGE_HI_BIT = 9;
	localparam int CFG_OC_SIGN_BIT  = 8;
	localparam int CFG_OUT_LSB      = 5;
	localparam int CFG_OUT_W        = 3;
	localparam int CFG_FILTER_LSB   = 3;
	localparam int CFG_FILTER_W     = 2;
	localparam int CFG_RANGE_LO_LSB = 1;
	localparam int CFG_RANGE_LO_W   = 2;
	localparam int CFG_OC_BIT       = 0;

endpackage

//--- design/nv_word_bank.sv
// Nonvolatile word bank with whole-bank erase and program
module nv_word_bank #(
	parameter int WORDS = 10,
	parameter int WIDTH = 14,
	parameter int LOCKW = 2
) (
	input  wire logic                     clk_in,
	input  wire logic                     arst_n_in,
	input  wire logic                     erase_in,
	input  wire logic                     program_in,
	input  wire logic [WORDS*WIDTH-1:0]   prog_data_in,
	input  wire logic [$clog2(WORDS)-1:0] rd_index_in,
	output logic      [WIDTH-1:0]         rd_data_out,
	input  wire logic                     lock_we_in,
	input  wire logic [LOCKW-1:0]         lock_data_in,
	output logic      [LOCKW-1:0]         lock_out
);

	logic [WIDTH-1:0] cell_reg [WORDS];
	logic [WIDTH-1:0] rd_next;
	// A blank part leaves the lock cells clear; they have no reset
	logic [LOCKW-1:0] lock_cell_reg = '0;

	initial begin
		if (WORDS < 2 || WIDTH < 1 || LOCKW < 1) begin
			$error("nv_word_bank: unsupported geometry");
		end
	end

	// Cells carry no reset: their content must survive power cycles
	for (genvar i = 0; i < WORDS; i++) begin : g_cell
		always_ff @(posedge clk_in) begin
			if (erase_in) begin
				cell_reg[i] <= '0;
			end else if (program_in) begin
				cell_reg[i] <= prog_data_in[i*WIDTH +: WIDTH];
			end
		end
	end

	// Lock bits sit outside the erase and program paths
	always_ff @(posedge clk_in) begin
		if (lock_we_in) begin
			lock_cell_reg <= lock_data_in;
		end
	end

	assign lock_out = lock_cell_reg;

	always_comb begin
		rd_next = cell_reg[rd_index_in];
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_data_out <= '0;
		end else begin
			rd_data_out <= rd_next;
		end
	end

endmodule

//--- test/sensor_prog_register_bank_asserts.sv
// Port-level checks for the sensor register bank
module sensor_prog_register_bank_asserts
	import sensor_prog_pkg::*;
#(
	parameter int GP_WORDS = GP_WORDS_DEF
) (
	input wire logic                   clk_in,
	input wire logic                   arst_n_in,
	input wire logic                   cmd_valid_in,
	input wire logic [2:0]             cmd_code_in,
	input wire logic [3:0]             cmd_addr_in,
	input wire logic [DATA_W-1:0]      payload_field_in,
	input wire logic                   activate_pin_in,
	input wire logic                   ack_out,
	input wire logic                   rsp_valid_out,
	input wire logic [DATA_W-1:0]      rsp_data_out,
	input wire logic                   sensor_active_out,
	input wire logic                   lock_active_out,
	input wire logic                   load_busy_out,
	input wire logic [LOW_LEVEL_W-1:0] output_low_level_out,
	input wire logic [GAIN_W-1:0]      gain_setting_out
);
	logic [3:0] pin_hist_reg;
	logic [3:0] pin_hist_next;
	logic       take;
	logic       wr;
	always_comb begin
		pin_hist_next = {pin_hist_reg[2:0], activate_pin_in};
	end
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_hist_reg <= 4'h0;
		end else begin
			pin_hist_reg <= pin_hist_next;
		end
	end
	// An activate edge still in the synchroniser may drop a command
	assign take = cmd_valid_in && !load_busy_out && sensor_active_out
		&& pin_hist_next == 4'h0;
	assign wr = take && cmd_code_in == CMD_WRITE && !lock_active_out;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	AST_READ_ANSWER: assert property (
		take && cmd_code_in == CMD_READ |=> ack_out && rsp_valid_out)
		else $error("read not answered");
	AST_IDLE_REFUSE: assert property (
		cmd_valid_in && (load_busy_out || !sensor_active_out) |=> !ack_out)
		else $error("ack while busy or inactive");
	AST_ACK_CAUSE: assert property (ack_out |-> $past(cmd_valid_in))
		else $error("ack without command");
	AST_STORE_ADDR: assert property (
		cmd_valid_in && cmd_addr_in != ADDR_STORE && (cmd_code_in ==
		CMD_ERASE || cmd_code_in == CMD_PROGRAM) |=> !ack_out)
		else $error("store with nonzero address acked");
	AST_LOCK_REFUSE: assert property (
		cmd_valid_in && lock_active_out && cmd_code_in == CMD_WRITE
		|=> !ack_out && $stable(output_low_level_out))
		else $error("write accepted while locked");
	AST_DISABLE_CODE: assert property (
		wr && cmd_addr_in == ADDR_DISABLE && payload_field_in[11:0] ==
		DISABLE_CODE |=> !sensor_active_out)
		else $error("disable code ignored");
	AST_WRONG_CODE: assert property (
		wr && cmd_addr_in == ADDR_DISABLE && payload_field_in[11:0] !=
		DISABLE_CODE |=> sensor_active_out)
		else $error("wrong code disabled sensor");
	AST_LOW_WRITE: assert property (wr && cmd_addr_in == ADDR_LOW_LEVEL
		|=> output_low_level_out == $past(payload_field_in[7:0]))
		else $error("low level not taken from low bits");
	AST_GAIN_READ: assert property (
		take && cmd_code_in == CMD_READ && cmd_addr_in == ADDR_GAIN
		|=> rsp_data_out == $past(gain_setting_out))
		else $error("gain read mismatch");
	AST_RO_WRITE: assert property (take && cmd_code_in == CMD_WRITE &&
		cmd_addr_in inside {4'h0, 4'h7, 4'h9, 4'hA, 4'hD, 4'hE}
		|=> $stable(output_low_level_out) && $stable(gain_setting_out))
		else $error("write to unassigned place changed a register");
	AST_LOCK_STEADY: assert property (
		!load_busy_out && !$past(load_busy_out) |-> $stable(lock_active_out))
		else $error("lock changed outside power-up");
	AST_REACTIVATE: assert property (
		$rose(activate_pin_in) |-> ##[1:6] sensor_active_out)
		else $error("activate pulse not honoured");
	COV_STORE: cover property (take && cmd_code_in == CMD_PROGRAM);
	COV_DISABLE: cover property (wr && cmd_addr_in == ADDR_DISABLE);
	COV_LOCKED: cover property (cmd_valid_in && lock_active_out);
endmodule

bind sensor_prog_register_bank sensor_prog_register_bank_asserts #(
	.GP_WORDS(GP_WORDS)
) chk (
	.clk_in(clk_in), .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid_in),
	.cmd_code_in(cmd_code_in), .cmd_addr_in(cmd_addr_in),
	.payload_field_in(payload_field_in), .activate_pin_in(activate_pin_in),
	.ack_out(ack_out), .rsp_valid_out(rsp_valid_out),
	.rsp_data_out(rsp_data_out), .sensor_active_out(sensor_active_out),
	.lock_active_out(lock_active_out), .load_busy_out(load_busy_out),
	.output_low_level_out(output_low_level_out),
	.gain_setting_out(gain_setting_out)
);

//--- test/programmer_model.sv
// Behavioural programmer: decoded telegrams and the activate pulse
module programmer_model
	import sensor_prog_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              ack_in,
	output logic                   cmd_valid_out,
	output logic [2:0]             cmd_code_out,
	output logic [3:0]             cmd_addr_out,
	output logic [DATA_W-1:0]      payload_field_out,
	output logic                   activate_pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmd_valid_out = 1'b0;
		cmd_code_out = 3'h0;
		cmd_addr_out = 4'h0;
		payload_field_out = 14'h0;
		activate_pin_out = 1'b0;
	end
	// Idle fields show inverted data so stale values never look valid
	task automatic send(input logic [2:0] code, input logic [3:0] addr,
		input logic [DATA_W-1:0] data, output logic acked);
		@(posedge clk_in);
		#5;
		cmd_valid_out = 1'b1;
		cmd_code_out = code;
		cmd_addr_out = addr;
		payload_field_out = data;
		@(posedge clk_in);
		#5;
		acked = ack_in;
		cmd_valid_out = 1'b0;
		cmd_code_out = ~code;
		cmd_addr_out = ~addr;
		payload_field_out = ~data;
	endtask
	task automatic pulse();
		@(posedge clk_in);
		#5;
		activate_pin_out = 1'b1;
		repeat (4) @(posedge clk_in);
		#5;
		activate_pin_out = 1'b0;
	endtask
endmodule

//--- test/sensor_prog_register_bank_tb.sv
// Self-checking bench for the sensor register bank
module sensor_prog_register_bank_tb
	import sensor_prog_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_in, arst_n_in, cmd_valid, act_pin, ack, rsp_valid;
	logic [2:0]  cmd_code, range_sel, beh_sel, sq_term;
	logic [3:0]  cmd_addr;
	logic [13:0] payload, conv, proc, rsp_data, gain;
	logic        active, locked, busy, oc_sign, oc_fix;
	logic [7:0]  low;
	logic [8:0]  high;
	logic [10:0] quiescent;
	logic [1:0]  filter_sel, grp;
	logic [4:0]  lin_term;
	int          errors, compares;
	sensor_prog_register_bank dut (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid),
		.cmd_code_in(cmd_code), .cmd_addr_in(cmd_addr),
		.payload_field_in(payload), .converter_sample_view_in(conv),
		.processed_value_capture_in(proc), .activate_pin_in(act_pin),
		.ack_out(ack), .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
		.sensor_active_out(active), .lock_active_out(locked),
		.load_busy_out(busy), .output_low_level_out(low),
		.output_high_level_out(high), .quiescent_output_level_out(quiescent),
		.gain_setting_out(gain), .range_select_out(range_sel),
		.offset_fix_sign_out(oc_sign), .output_behaviour_select_out(beh_sel),
		.filter_select_out(filter_sel), .offset_fix_out(oc_fix),
		.square_term_value_out(sq_term), .linear_term_value_out(lin_term),
		.coefficient_group_out(grp));
	programmer_model prog (
		.clk_in(clk_in), .ack_in(ack), .cmd_valid_out(cmd_valid),
		.cmd_code_out(cmd_code), .cmd_addr_out(cmd_addr),
		.payload_field_out(payload), .activate_pin_out(act_pin));
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	task automatic close_out();
		if (errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [13:0] exp,
		input logic [13:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [13:0] pat(input logic [3:0] a);
		return 14'h3E50 | {10'h0, a};
	endfunction
	function automatic logic [13:0] align(input logic [13:0] d, input int w);
		return (d & (14'h3FFF >> (14 - w))) << (14 - w);
	endfunction
	task automatic cmd(input logic [2:0] c, input logic [3:0] a,
		input logic [13:0] d, input logic exp_ack);
		logic acked;
		prog.send(c, a, d, acked);
		check("ack", 14'(exp_ack), 14'(acked));
	endtask
	task automatic wr(input logic [3:0] a, input logic [13:0] d);
		cmd(CMD_WRITE, a, d, 1'b1);
	endtask
	task automatic rd(input logic [3:0] a, input logic [13:0] exp);
		cmd(CMD_READ, a, 14'h0, 1'b1);
		check("rsp_valid", 14'h1, 14'(rsp_valid));
		check("rsp_data", exp, rsp_data);
	endtask
	task automatic do_reset();
		int n;
		arst_n_in = 1'b0;
		repeat (6) @(posedge clk_in);
		#5;
		arst_n_in = 1'b1;
		for (n = 0; n < 40 && busy !== 1'b0; n++) begin
			@(posedge clk_in);
			#5;
		end
		check("load_busy", 14'h0, 14'(busy));
		if (busy !== 1'b0) close_out();
	endtask
	task automatic t_fields();
		logic [3:0] a[6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hB};
		int w[6] = '{LOW_LEVEL_W, HIGH_LEVEL_W, QUIESCENT_W, GAIN_W,
			CONFIG_W, TEMP_COEF_W};
		logic [13:0] c = pat(ADDR_CONFIG);
		logic [13:0] t = pat(ADDR_TEMP_COEF);
		foreach (a[i]) wr(a[i], pat(a[i]));
		cmd(CMD_ERASE, ADDR_STORE, 14'h0, 1'b1);
		cmd(CMD_PROGRAM, ADDR_STORE, 14'h0, 1'b1);
		foreach (a[i]) rd(a[i], align(pat(a[i]), w[i]));
		check("low", pat(4'h1) & 14'h00FF, 14'(low));
		check("high", pat(4'h2) & 14'h01FF, 14'(high));
		check("quiescent", pat(4'h3) & 14'h07FF, 14'(quiescent));
		check("gain", pat(4'h4), gain);
		check("range", 14'({c[9], c[2:1]}), 14'(range_sel));
		check("cfg", 14'({c[8], c[7:5], c[4:3], c[0]}),
			14'({oc_sign, beh_sel, filter_sel, oc_fix}));
		check("tc", 14'(t[9:0]), 14'({grp, lin_term, sq_term}));
	endtask
	task automatic t_readouts();
		logic [3:0] ro[6] = '{4'h0, 4'h7, 4'h9, 4'hA, 4'hD, 4'hE};
		logic [13:0] rev;
		conv = 14'h2C35;
		proc = 14'h0C4B;
		for (int i = 0; i < 14; i++) rev[13 - i] = proc[i];
		foreach (ro[i]) wr(ro[i], 14'h3FFF);
		foreach (ro[i]) rd(ro[i], i == 1 ? conv : i == 2 ? rev : 14'h0);
		rd(ADDR_DISABLE, 14'h0);
		rd(ADDR_GAIN, pat(ADDR_GAIN));
	endtask
	task automatic t_spare();
		logic [12:0] v[4] = '{13'h0A51, 13'h1B62, 13'h0C73, 13'h1D84};
		cmd(CMD_READ, ADDR_SPARE_0, 14'h0, 1'b1);
		for (int i = 1; i < 4; i++) begin
			cmd(CMD_READ, ADDR_SPARE_123, 14'h0, 1'b1);
		end
		wr(ADDR_SPARE_0, 14'(v[0]));
		for (int i = 1; i < 4; i++) wr(ADDR_SPARE_123, {1'b1, v[i]});
		cmd(CMD_ERASE, ADDR_STORE, 14'h0, 1'b1);
		cmd(CMD_PROGRAM, ADDR_STORE, 14'h0, 1'b1);
		rd(ADDR_SPARE_0, {v[0], 1'b0});
		for (int i = 0; i < 4; i++) rd(ADDR_SPARE_123, {v[i % 3 + 1], 1'b0});
	endtask
	task automatic t_store();
		cmd(CMD_ERASE, 4'h3, 14'h0, 1'b0);
		cmd(CMD_PROGRAM, 4'h5, 14'h0, 1'b0);
		cmd(3'h7, ADDR_STORE, 14'h0, 1'b0);
		cmd(CMD_ERASE, ADDR_STORE, 14'h0, 1'b1);
		cmd(CMD_PROGRAM, ADDR_STORE, 14'h0, 1'b1);
		wr(ADDR_LOW_LEVEL, 14'h0077);
		do_reset();
		check("low", pat(4'h1) & 14'h00FF, 14'(low));
		check("gain", pat(4'h4), gain);
		cmd(CMD_ERASE, ADDR_STORE, 14'h0, 1'b1);
		do_reset();
		check("low", 14'h0, 14'(low));
		check("gain", 14'h0, gain);
	endtask
	task automatic t_disable();
		wr(ADDR_DISABLE, 14'h080E);
		check("active", 14'h1, 14'(active));
		wr(ADDR_DISABLE, 14'h380F);
		check("active", 14'h0, 14'(active));
		cmd(CMD_READ, ADDR_GAIN, 14'h0, 1'b0);
		prog.pulse();
		check("active", 14'h1, 14'(active));
		rd(ADDR_GAIN, 14'h0);
	endtask
	task automatic t_lock();
		wr(ADDR_PROTECT, 14'h0001);
		check("lock", 14'h0, 14'(locked));
		wr(ADDR_LOW_LEVEL, 14'h0033);
		rd(ADDR_PROTECT, 14'h1000);
		do_reset();
		check("lock", 14'h1, 14'(locked));
		cmd(CMD_WRITE, ADDR_LOW_LEVEL, 14'h0044, 1'b0);
		cmd(CMD_ERASE, ADDR_STORE, 14'h0, 1'b0);
		rd(ADDR_LOW_LEVEL, 14'h0);
	endtask
	initial begin
		logic dummy;
		errors = 0;
		compares = 0;
		arst_n_in = 1'b0;
		conv = 14'h0;
		proc = 14'h0;
		do_reset();
		// Stored lock bits power up clear; write them clear again before anything else
		prog.send(CMD_WRITE, ADDR_PROTECT, 14'h0, dummy);
		do_reset();
		t_fields();
		t_readouts();
		t_spare();
		t_store();
		t_disable();
		t_lock();
		close_out();
	end
endmodule
